// ### hw/sacp_top.sv
// Purpose: control and serial port of a multichannel serial converter
// Assumes: SPI mode 0 host, core result valid when conversion time ends
// Notes: link logic runs on IO_CLK; all of it but cmd_q and cfg_q is held cleared while CS_N is high
`timescale 1ns/100ps
// Contract
// - chip select fall clears counters, enables port
// - chip select rise stops input and clock
// - four command bits, msb first, rising edges
// - four configuration bits follow on rising edges
// - code selects external input or test voltage
// - output high impedance while chip select high
// - first result bit driven at chip select fall
// - each falling edge advances output bit
// - eoc low after last edge until done
// - eoc high once conversion completes
// - mode 0 serial port, up to 15 MHz
// - configurable output frame length
// - configurable msb or lsb first
// - unipolar or bipolar result coding
// - power-down command halts conversion until reactivated
// - internal timebase times conversion, automatic sampling
// - sampling from fourth falling edge to last
// - last falling edge hands over to controller
// - remaining result bits change on falling edges
module sacp_top
    import sacp_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic IO_CLK,
    input wire logic CS_N,
    input wire logic DATA_IN,
    output logic DATA_OUT,
    output logic DATA_OUT_OE,
    output logic EOC,
    output logic [3:0] MUX_SEL,
    output logic SELF_TEST,
    output logic SAMPLE_EN,
    output logic CONV_START,
    output logic POWER_DOWN,
    input wire logic [RESULT_W-1:0] ADC_RESULT
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } sacp_state_e;

    // frame length in bits from a configuration code
    function automatic logic [CNT_W-1:0] frame_len(input logic [1:0] code);
        case (code)
            LEN_CODE_8: frame_len = LEN_8;
            LEN_CODE_16: frame_len = LEN_16;
            default: frame_len = LEN_12;
        endcase
    endfunction

    // index into the left-aligned output word for serial position n
    function automatic logic [3:0] bit_index(input logic [CNT_W-1:0] n,
        input logic lsb_first, input logic [CNT_W-1:0] len);
        logic [CNT_W-1:0] idx;
        idx = 5'h00;
        if (lsb_first) begin
            idx = (LEN_16 - len) + n;
        end else begin
            idx = (LEN_16 - 5'h01) - n;
        end
        bit_index = idx[3:0];
    endfunction

    // link side, rising edges
    logic [IN_BITS-1:0] in_shift_q;
    logic [3:0] rx_cnt_q;
    logic [CMD_W-1:0] cmd_q;
    logic [CFG_W-1:0] cfg_q;
    // link side, falling edges
    logic [CNT_W-1:0] tx_cnt_q;
    logic sample_q;
    logic done_q;
    // system side
    sacp_state_e state_q;
    logic [CONV_CNT_W-1:0] conv_cnt_q;
    logic done_s;
    logic done_d1_q;
    logic handover;
    logic eoc_q;
    logic pd_q;
    logic start_q;
    logic [CMD_W-1:0] conv_cmd_q;
    logic [CFG_W-1:0] conv_cfg_q;
    logic [CFG_W-1:0] fmt_cfg_q;
    logic [WORD_W-1:0] word_q;
    logic [WORD_W-1:0] word_d;
    logic [RESULT_W-1:0] coded;
    logic [CNT_W-1:0] out_len;

    // chip select high holds every link flop but cmd_q and cfg_q cleared, so a fall starts clean
    always_ff @(posedge IO_CLK or posedge CS_N) begin
        if (CS_N) begin
            in_shift_q <= 8'h00;
            rx_cnt_q <= 4'h0;
        end else if (rx_cnt_q != 4'(IN_BITS)) begin
            in_shift_q <= {in_shift_q[IN_BITS-2:0], DATA_IN};
            rx_cnt_q <= rx_cnt_q + 4'h1;
        end
    end

    // command keeps its value across chip select so the mux stays put
    always_ff @(posedge IO_CLK) begin
        if (!CS_N && rx_cnt_q == 4'(CMD_W - 1)) begin
            cmd_q <= {in_shift_q[CMD_W-2:0], DATA_IN};
        end
    end

    always_ff @(posedge IO_CLK) begin
        if (!CS_N && rx_cnt_q == 4'(IN_BITS - 1)) begin
            cfg_q <= {in_shift_q[CFG_W-2:0], DATA_IN};
        end
    end

    assign MUX_SEL = cmd_q;
    assign SELF_TEST = (cmd_q > CMD_LAST_EXT) && (cmd_q <= CMD_LAST_TEST);

    // out_len is quasi-static: it only moves while eoc is low
    always_ff @(negedge IO_CLK or posedge CS_N) begin
        if (CS_N) begin
            tx_cnt_q <= 5'h00;
            sample_q <= 1'b0;
            done_q <= 1'b0;
        end else if (!done_q) begin
            tx_cnt_q <= tx_cnt_q + 5'h01;
            if (tx_cnt_q + 5'h01 == SAMPLE_EDGE) begin
                sample_q <= 1'b1;
            end
            if (tx_cnt_q + 5'h01 == out_len) begin
                sample_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    assign SAMPLE_EN = sample_q;

    // word_q is stable for the whole frame while the host waits for eoc
    assign DATA_OUT = CS_N ? 1'b0
        : word_q[bit_index(tx_cnt_q, fmt_cfg_q[CFG_LSB_FIRST], out_len)];
    assign DATA_OUT_OE = !CS_N;
    assign out_len = frame_len(fmt_cfg_q[CFG_LEN_HI:CFG_LEN_LO]);

    // handover flag stays high until chip select rises, long enough to cross
    sacp_sync u_done_sync (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .din(done_q),
        .dout(done_s)
    );

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            done_d1_q <= 1'b0;
        end else begin
            done_d1_q <= done_s;
        end
    end

    assign handover = done_s && !done_d1_q;

    // cmd and cfg are stable once the last falling edge has passed
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            conv_cmd_q <= CMD_NOP;
            conv_cfg_q <= CFG_RESET;
        end else if (handover) begin
            conv_cmd_q <= cmd_q;
            conv_cfg_q <= cfg_q;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            pd_q <= 1'b0;
        end else if (handover) begin
            pd_q <= (cmd_q == CMD_POWER_DOWN);
        end
    end

    assign POWER_DOWN = pd_q;

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            conv_cnt_q <= 12'h000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (handover && cmd_q != CMD_POWER_DOWN) begin
                        state_q <= ST_CONV;
                        conv_cnt_q <= 12'h000;
                    end
                end
                ST_CONV: begin
                    conv_cnt_q <= conv_cnt_q + 12'h001;
                    if (conv_cnt_q == CONV_CNT_W'(CONV_LEN - 1)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            start_q <= 1'b0;
        end else begin
            start_q <= (state_q == ST_IDLE) && handover && (cmd_q != CMD_POWER_DOWN);
        end
    end

    assign CONV_START = start_q;

    wire conv_end = (state_q == ST_CONV) && (conv_cnt_q == CONV_CNT_W'(CONV_LEN - 1));

    // low from handover until the result is loaded
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            eoc_q <= 1'b1;
        end else if (handover && cmd_q != CMD_POWER_DOWN) begin
            eoc_q <= 1'b0;
        end else if (conv_end) begin
            eoc_q <= 1'b1;
        end
    end

    assign EOC = eoc_q;

    // bipolar coding is two's complement: flip the top bit of the straight code
    always_comb begin
        coded = ADC_RESULT;
        if (conv_cfg_q[CFG_BIPOLAR]) begin
            coded[RESULT_W-1] = !ADC_RESULT[RESULT_W-1];
        end
        word_d = {coded, 4'h0};
    end

    // result and its format change together, only at conversion end
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            word_q <= WORD_RESET;
            fmt_cfg_q <= CFG_RESET;
        end else if (conv_end) begin
            word_q <= word_d;
            fmt_cfg_q <= conv_cfg_q;
        end
    end
endmodule

// ### hw/sacp_pkg.sv
// Purpose: constants shared by the serial converter control port
// Assumes: 12-bit converter core, frame of up to 16 output bits
// Notes: the conversion cycle count derives from the 100 MHz system clock
package sacp_pkg;
    localparam int SYS_CLK_MHZ = 100;
    localparam int RESULT_W = 12;
    localparam int WORD_W = 16;
    localparam int CMD_W = 4;
    localparam int CFG_W = 4;
    localparam int IN_BITS = CMD_W + CFG_W;
    localparam int CNT_W = 5;
    // channel and command codes
    localparam logic [3:0] CMD_LAST_EXT = 4'hA;
    localparam logic [3:0] CMD_LAST_TEST = 4'hD;
    localparam logic [3:0] CMD_POWER_DOWN = 4'hE;
    localparam logic [3:0] CMD_NOP = 4'hF;
    // configuration field positions
    localparam int CFG_LEN_HI = 3;
    localparam int CFG_LEN_LO = 2;
    localparam int CFG_LSB_FIRST = 1;
    localparam int CFG_BIPOLAR = 0;
    // frame length codes and lengths
    localparam logic [1:0] LEN_CODE_8 = 2'h1;
    localparam logic [1:0] LEN_CODE_16 = 2'h2;
    localparam logic [4:0] LEN_8 = 5'h08;
    localparam logic [4:0] LEN_12 = 5'h0C;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] SAMPLE_EDGE = 5'h04;
    // values after reset
    localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    // conversion time from the internal timebase, rounded up
    localparam int CONV_TIME_NS = 2000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CONV_CNT_W = 12;
endpackage

// ### hw/sacp_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input is a slow level
// Notes: first stage is read by the second stage only
`timescale 1ns/100ps
module sacp_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// ### dv/sacp_top_assertions.sv
// Purpose: port checks for the converter control port
// Assumes: CONV_LEN handed down by the bind
// Notes: link signals are sampled on the system clock
`timescale 1ns/100ps
module sacp_checker #(
    parameter int CONV_LEN = 8
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic IO_CLK,
    input wire logic CS_N,
    input wire logic DATA_OUT,
    input wire logic DATA_OUT_OE,
    input wire logic EOC,
    input wire logic [3:0] MUX_SEL,
    input wire logic SELF_TEST,
    input wire logic SAMPLE_EN,
    input wire logic CONV_START,
    input wire logic POWER_DOWN
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);
    oe_follows_cs_a: assert property (DATA_OUT_OE == !CS_N)
        else $error("output enable not tied to select");
    self_test_map_a: assert property (SAMPLE_EN |-> SELF_TEST == (MUX_SEL >= 4'hB && MUX_SEL <= 4'hD))
        else $error("self test flag wrong for code");
    sample_in_frame_a: assert property (SAMPLE_EN |-> !CS_N)
        else $error("sampling outside a frame");
    data_on_fall_a: assert property ($changed(DATA_OUT) && !CS_N && $past(!CS_N) |-> $fell(IO_CLK))
        else $error("data moved off a falling edge");
    handover_start_a: assert property ($fell(SAMPLE_EN) && !CS_N && MUX_SEL != 4'hE |-> ##[2:8] CONV_START)
        else $error("no conversion after frame end");
    eoc_fall_cause_a: assert property ($fell(EOC) |-> CONV_START)
        else $error("eoc fell without a start");
    conv_time_a: assert property (CONV_START |-> ##CONV_LEN $rose(EOC))
        else $error("conversion time wrong");
    start_pulse_a: assert property (CONV_START |=> !CONV_START)
        else $error("start pulse too long");
    pd_idle_a: assert property ($rose(POWER_DOWN) |-> EOC [*4])
        else $error("converter busy in power down");
endmodule
bind sacp_top sacp_checker #(.CONV_LEN(CONV_LEN)) u_sacp_checker (.SYS_CLK, .RESETN, .IO_CLK,
    .CS_N, .DATA_OUT, .DATA_OUT_OE, .EOC, .MUX_SEL, .SELF_TEST, .SAMPLE_EN, .CONV_START, .POWER_DOWN);

// ### dv/sacp_host.sv
// Purpose: mode 0 serial host driving the port
// Assumes: 160 ns serial clock, stopped between frames
// Notes: a released data line reads as z
`timescale 1ns/100ps
module sacp_host (
    output logic io_clk,
    output logic cs_n,
    output logic data_in,
    input wire logic data_out,
    input wire logic data_out_oe
);
    initial begin
        io_clk = 1'b0;
        cs_n = 1'b1;
        data_in = 1'b0;
    end
    // offset keeps link edges away from system clock edges
    task automatic frame(input logic [7:0] bits, input int len, output logic [15:0] rx);
        rx = 16'h0000;
        #3;
        cs_n = 1'b0;
        data_in = bits[7];
        #80;
        for (int i = 0; i < len; i++) begin
            io_clk = 1'b1;
            rx[i] = data_out_oe ? data_out : 1'bz;
            #80;
            io_clk = 1'b0;
            data_in = (i < 7) ? bits[6 - i] : ~data_in;
            #80;
        end
        cs_n = 1'b1;
        data_in = ~data_in;
    endtask
endmodule

// ### dv/testbench.sv
// Purpose: self checking bench for the converter control port
// Assumes: short conversion via CONV_LEN
// Notes: each frame returns the result of the last conversion before it, or zero if none since reset
`timescale 1ns/100ps
module testbench;
    import sacp_pkg::*;
    localparam int CL = 20;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] adc = 12'h000;
    wire io_clk, cs_n, data_in, data_out, oe, eoc, self_test, sample_en, conv_start, pd;
    wire [3:0] mux_sel;
    int failures = 0;
    int comparisons = 0;
    logic [15:0] rx;
    logic [11:0] p_adc = 12'h000;
    logic [3:0] p_cfg = 4'h0;
    // command, configuration, converter value
    logic [19:0] rows [8] = '{20'h00ABC, 20'h34123, 20'hAA5A5, 20'hB1FFF,
        20'hC6800, 20'hD97FF, 20'hE9111, 20'hF0222};
    always #5 sys_clk = ~sys_clk;
    sacp_top #(.CONV_LEN(CL)) u_sacp_top (.SYS_CLK(sys_clk), .RESETN(resetn), .IO_CLK(io_clk),
        .CS_N(cs_n), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OUT_OE(oe), .EOC(eoc),
        .MUX_SEL(mux_sel), .SELF_TEST(self_test), .SAMPLE_EN(sample_en),
        .CONV_START(conv_start), .POWER_DOWN(pd), .ADC_RESULT(adc));
    sacp_host u_sacp_host (.io_clk(io_clk), .cs_n(cs_n), .data_in(data_in),
        .data_out(data_out), .data_out_oe(oe));
    function automatic logic [4:0] flen(input logic [3:0] c);
        return (c[3:2] == LEN_CODE_8) ? LEN_8 : (c[3:2] == LEN_CODE_16) ? LEN_16 : LEN_12;
    endfunction
    function automatic logic [15:0] fmt(input logic [11:0] a, input logic [3:0] c);
        logic [15:0] w;
        int n;
        w = {a ^ {c[CFG_BIPOLAR], 11'h000}, 4'h0};
        n = int'(flen(c));
        fmt = 16'h0000;
        for (int i = 0; i < n; i++) fmt[i] = c[CFG_LSB_FIRST] ? w[16 - n + i] : w[15 - i];
    endfunction
    task automatic finish_test();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_eoc(input logic lvl);
        int n;
        for (n = 0; n < 400 && eoc !== lvl; n++) @(posedge sys_clk);
        check(16'(eoc), 16'(lvl));
        if (n == 400) finish_test();
    endtask
    task automatic conv_done();
        wait_eoc(1'b0);
        wait_eoc(1'b1);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk) adc <= rows[k][11:0];
            u_sacp_host.frame(rows[k][19:12], int'(flen(p_cfg)), rx);
            check(rx, fmt(p_adc, p_cfg));
            check(16'(mux_sel), 16'(rows[k][19:16]));
            check(16'(self_test), 16'(rows[k][19:16] >= 4'hB && rows[k][19:16] <= 4'hD));
            if (rows[k][19:16] == CMD_POWER_DOWN) begin
                repeat (20) @(posedge sys_clk);
                check(16'({pd, eoc}), 16'h3);
            end else begin
                conv_done();
                p_adc = rows[k][11:0];
                p_cfg = rows[k][15:12];
            end
        end
        check(16'(pd), 16'h0);
        // frame cut short: no conversion, next frame starts clean
        u_sacp_host.frame(8'h50, 6, rx);
        repeat (20) @(posedge sys_clk);
        check(16'(eoc), 16'h1);
        u_sacp_host.frame(8'h50, int'(flen(p_cfg)), rx);
        check(rx, fmt(p_adc, p_cfg));
        conv_done();
        @(posedge sys_clk) resetn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check(16'({pd, eoc}), 16'h1);
        u_sacp_host.frame(8'h00, 12, rx);
        check(rx, 16'h0000);
        conv_done();
        finish_test();
    end
endmodule
